// file: hdl/acr_cell_receive_port.sv
// receive cell port: per-port buffers, pin-side transfer, parity and available flags
`timescale 1ns/1ps
`default_nettype none
module acr_cell_receive_port #(
	parameter int NUM_PORTS = acr_pkg::ACR_NUM_PORTS,
	parameter int FIFO_WORDS = acr_pkg::ACR_FIFO_WORDS,
	parameter int CELL_WORDS = acr_pkg::ACR_CELL_WORDS
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// cells from the receive core
	input wire logic cellInValid,
	input wire logic [acr_pkg::ACR_WORD_W-1:0] cellInWord,
	input wire logic cellInLast,
	input wire logic [acr_pkg::ACR_SEL_W-1:0] cellInPort,
	output logic [NUM_PORTS-1:0] cellInSpace,
	// mode
	input wire logic paritySenseSelect,
	// pins toward the cell layer device
	input wire logic cellRxClock,
	input wire logic cellRxReadEnableN,
	input wire logic [acr_pkg::ACR_SEL_W-1:0] cellRxPortSelect,
	output logic [acr_pkg::ACR_WORD_W-1:0] cellRxWord,
	output logic cellRxFirstWord,
	output logic cellRxParity,
	output logic [NUM_PORTS-1:0] cellRxAvailable
);
	import acr_pkg::*;

	localparam int LW = $clog2(FIFO_WORDS+1);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic rxClkMeta;
	logic rxClkSync;
	logic rxClkPrev;
	logic enMeta;
	logic enSyncN;
	logic [ACR_SEL_W-1:0] selMeta;
	logic [ACR_SEL_W-1:0] selSync;
	logic rxEdge;
	acr_state_t stateReg;
	logic [ACR_IDX_W-1:0] wordCnt;
	logic [ACR_SEL_W-1:0] curPort;
	logic [ACR_SEL_W-1:0] rdPort;
	logic startCell;
	logic advance;
	logic [ACR_WORD_W-1:0] portData [NUM_PORTS];
	logic [LW-1:0] portLevel [NUM_PORTS];
	logic [ACR_CNT_W-1:0] cellCnt [NUM_PORTS];
	logic [NUM_PORTS-1:0] wholeCell;
	logic [NUM_PORTS-1:0] portReady;
	logic [ACR_WORD_W-1:0] next_word;
	logic next_parity;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// the receive clock is only sampled here, so it must stay well under half
	// of clk; a full-rate receive clock needs a second domain instead
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxClkMeta <= 1'h0;
			rxClkSync <= 1'h0;
			rxClkPrev <= 1'h0;
		end else begin
			rxClkMeta <= cellRxClock;
			rxClkSync <= rxClkMeta;
			rxClkPrev <= rxClkSync;
		end
	end

	// enable and port select pass the same two stages, so they line up with the edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enMeta <= 1'h1;
			enSyncN <= 1'h1;
			selMeta <= '0;
			selSync <= '0;
		end else begin
			enMeta <= cellRxReadEnableN;
			enSyncN <= enMeta;
			selMeta <= cellRxPortSelect;
			selSync <= selMeta;
		end
	end

	assign rxEdge = rxClkSync && !rxClkPrev;

	// ----------------------------------------------------------------
	// per-port buffers and whole-cell counts
	// ----------------------------------------------------------------
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
			logic wrThis;
			logic wrReadyThis;
			logic cellDone;
			logic rdThis;

			assign wrThis = cellInValid && (cellInPort == ACR_SEL_W'(gp));
			assign rdThis = advance && (rdPort == ACR_SEL_W'(gp));
			assign cellDone = wrThis && wrReadyThis && cellInLast;
			assign wholeCell[gp] = (cellCnt[gp] != '0);
			assign portReady[gp] = (portLevel[gp] < LW'(FIFO_WORDS - 1));

			acr_port_fifo #(
				.WIDTH(ACR_WORD_W),
				.DEPTH(FIFO_WORDS)
			) u_fifo (
				.clk(clk),
				.rst(rst),
				.wrValid(wrThis),
				.wrData(cellInWord),
				.wrReady(wrReadyThis),
				.rdEn(rdThis),
				.rdData(portData[gp]),
				.level(portLevel[gp])
			);

			// a cell stops counting as waiting the moment its transfer starts
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					cellCnt[gp] <= '0;
				end else if (cellDone && !(startCell && rdPort == ACR_SEL_W'(gp))) begin
					cellCnt[gp] <= cellCnt[gp] + ACR_CNT_W'(1);
				end else if (!cellDone && startCell && rdPort == ACR_SEL_W'(gp)) begin
					cellCnt[gp] <= cellCnt[gp] - ACR_CNT_W'(1);
				end
			end
		end
	endgenerate

	// space flags lag one cycle, so they keep one word in reserve
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cellInSpace <= '0;
		end else begin
			cellInSpace <= portReady;
		end
	end

	// ----------------------------------------------------------------
	// transfer sequencer
	// ----------------------------------------------------------------
	// mid-cell the select lines are ignored; a cell always finishes on its port
	assign rdPort = (stateReg == ACR_IDLE) ? selSync : curPort;
	assign startCell = rxEdge && !enSyncN && (stateReg == ACR_IDLE) && wholeCell[selSync];
	assign advance = startCell || (rxEdge && !enSyncN && stateReg == ACR_XFER);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stateReg <= ACR_IDLE;
			wordCnt <= '0;
			curPort <= '0;
		end else begin
			case (stateReg)
				ACR_IDLE: begin
					if (startCell) begin
						curPort <= selSync;
						wordCnt <= ACR_IDX_W'(1);
						stateReg <= ACR_XFER;
					end
				end
				ACR_XFER: begin
					if (advance) begin
						if (wordCnt == ACR_IDX_W'(CELL_WORDS - 1)) begin
							wordCnt <= '0;
							stateReg <= ACR_IDLE;
						end else begin
							wordCnt <= wordCnt + ACR_IDX_W'(1);
						end
					end
				end
				default: begin
					stateReg <= ACR_IDLE;
					wordCnt <= '0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// pin-side outputs, all changed only at a receive clock edge
	// ----------------------------------------------------------------
	// buffer bit 31 goes to bus bit 31 unchanged, so the order is kept
	assign next_word = advance ? portData[rdPort] : cellRxWord;

	acr_parity_gen #(
		.WIDTH(ACR_WORD_W)
	) u_parity (
		.word(next_word),
		.evenSense(paritySenseSelect),
		.parity(next_parity)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cellRxWord <= ACR_WORD_RST;
			cellRxParity <= ACR_PARITY_RST;
		end else if (rxEdge) begin
			cellRxWord <= next_word;
			cellRxParity <= next_parity;
		end
	end

	// marker is held with the word when enable is high; dropped when idle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cellRxFirstWord <= 1'h0;
		end else if (rxEdge && !enSyncN) begin
			cellRxFirstWord <= startCell;
		end
	end

	// flags take the count after the start edge, i.e. one edge after it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cellRxAvailable <= '0;
		end else if (rxEdge) begin
			cellRxAvailable <= wholeCell;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_no_edge;
		!rxEdge;
	endsequence
	sequence s_held_edge;
		rxEdge && enSyncN;
	endsequence
	sequence s_word_start;
		startCell ##1 (stateReg == ACR_XFER);
	endsequence

	property p_word_on_edge;
		@(posedge clk) disable iff (rst)
		s_no_edge |=> $stable(cellRxWord);
	endproperty
	a_word_on_edge: assert property (p_word_on_edge) else $error("word moved off an edge");

	property p_word_order;
		@(posedge clk) disable iff (rst)
		advance |=> (cellRxWord == $past(portData[rdPort]));
	endproperty
	a_word_order: assert property (p_word_order) else $error("word not from buffer");

	property p_first_marks_start;
		@(posedge clk) disable iff (rst)
		s_word_start |-> cellRxFirstWord && (wordCnt == ACR_IDX_W'(1));
	endproperty
	a_first_marks_start: assert property (p_first_marks_start) else $error("marker missed");

	property p_first_only_first;
		@(posedge clk) disable iff (rst)
		cellRxFirstWord |-> (wordCnt == ACR_IDX_W'(1)) || (CELL_WORDS == 1);
	endproperty
	a_first_only_first: assert property (p_first_only_first) else $error("marker late");

	property p_advance;
		@(posedge clk) disable iff (rst)
		(rxEdge && !enSyncN && stateReg == ACR_XFER && wordCnt != ACR_IDX_W'(CELL_WORDS - 1))
		|=> (wordCnt == $past(wordCnt) + ACR_IDX_W'(1));
	endproperty
	a_advance: assert property (p_advance) else $error("enabled edge did not advance");

	property p_hold;
		@(posedge clk) disable iff (rst)
		s_held_edge |=> $stable(cellRxWord) && $stable(cellRxFirstWord) && $stable(wordCnt);
	endproperty
	a_hold: assert property (p_hold) else $error("held edge changed outputs");

	property p_parity_odd;
		@(posedge clk) disable iff (rst)
		(rxEdge && !paritySenseSelect) |=> ((^cellRxWord) ^ cellRxParity);
	endproperty
	a_parity_odd: assert property (p_parity_odd) else $error("odd parity wrong");

	property p_parity_even;
		@(posedge clk) disable iff (rst)
		(rxEdge && paritySenseSelect) |=> !((^cellRxWord) ^ cellRxParity);
	endproperty
	a_parity_even: assert property (p_parity_even) else $error("even parity wrong");

	property p_available;
		@(posedge clk) disable iff (rst)
		rxEdge |=> (cellRxAvailable == $past(wholeCell));
	endproperty
	a_available: assert property (p_available) else $error("available flag wrong");
endmodule // acr_cell_receive_port
`default_nettype wire

// file: hdl/acr_parity_gen.sv
// parity generator over one receive word
`timescale 1ns/1ps
`default_nettype none
module acr_parity_gen #(
	parameter int WIDTH = 32
) (
	// word and sense
	input wire logic [WIDTH-1:0] word,
	input wire logic evenSense,
	// result
	output logic parity
);
	// ----------------------------------------------------------------
	// parity over every bit; odd unless even is chosen
	// ----------------------------------------------------------------
	always_comb begin
		parity = (^word) ^ ~evenSense;
	end
endmodule // acr_parity_gen
`default_nettype wire

// file: hdl/acr_pkg.sv
// shared constants and types of the cell receive port
package acr_pkg;
	// ----------------------------------------------------------------
	// bus and port geometry
	// ----------------------------------------------------------------
	localparam int ACR_WORD_W = 32;
	localparam int ACR_NUM_PORTS = 4;
	localparam int ACR_SEL_W = 2;
	localparam int ACR_BYTES_PER_WORD = 4;
	localparam int ACR_FIFO_BYTES = 1024;
	localparam int ACR_FIFO_WORDS = ACR_FIFO_BYTES / ACR_BYTES_PER_WORD;
	localparam int ACR_CELL_WORDS = 13;
	localparam int ACR_CNT_W = 8;
	localparam int ACR_IDX_W = 4;

	// ----------------------------------------------------------------
	// clocking figures
	// ----------------------------------------------------------------
	localparam int ACR_CLK_MHZ = 50;
	localparam int ACR_RX_CLK_MAX_MHZ = 104;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [ACR_WORD_W-1:0] ACR_WORD_RST = 32'h0000_0000;
	localparam logic ACR_PARITY_RST = 1'h1;

	// ----------------------------------------------------------------
	// transfer sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ACR_IDLE = 2'h1,
		ACR_XFER = 2'h2
	} acr_state_t;
endpackage

// file: hdl/acr_port_fifo.sv
// one port's receive word buffer
`timescale 1ns/1ps
`default_nettype none
module acr_port_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 256
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// fill side
	input wire logic wrValid,
	input wire logic [WIDTH-1:0] wrData,
	output logic wrReady,
	// drain side
	input wire logic rdEn,
	output logic [WIDTH-1:0] rdData,
	output logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int PW = $clog2(DEPTH);
	localparam int LW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wrPtr;
	logic [PW-1:0] rdPtr;
	logic doWr;
	logic doRd;

	// accept only while room remains; reads of an empty buffer are ignored
	assign wrReady = (level < LW'(DEPTH));
	assign doWr = wrValid && wrReady;
	assign doRd = rdEn && (level != '0);
	assign rdData = mem[rdPtr];

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (doWr) begin
			mem[wrPtr] <= wrData;
		end
	end

	// pointers wrap at the depth, which need not be a power of two
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
		end else begin
			if (doWr) begin
				wrPtr <= (wrPtr == PW'(DEPTH-1)) ? '0 : wrPtr + PW'(1);
			end
			if (doRd) begin
				rdPtr <= (rdPtr == PW'(DEPTH-1)) ? '0 : rdPtr + PW'(1);
			end
		end
	end

	// fill level
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			level <= '0;
		end else if (doWr && !doRd) begin
			level <= level + LW'(1);
		end else if (doRd && !doWr) begin
			level <= level - LW'(1);
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_no_overfill;
		@(posedge clk) disable iff (rst)
		(level == LW'(DEPTH)) && wrValid && !doRd |=> (level == LW'(DEPTH));
	endproperty
	a_no_overfill: assert property (p_no_overfill) else $error("buffer grew past its depth");
endmodule // acr_port_fifo
`default_nettype wire

// file: tb/acr_cell_layer_model.sv
// cell layer device model: receive clock, read enable and port select
`timescale 1ns/1ps
`default_nettype none
module acr_cell_layer_model (
	// pacing clock
	input wire logic clk,
	// pins toward the port
	output logic cellRxClock,
	output logic cellRxReadEnableN,
	output logic [acr_pkg::ACR_SEL_W-1:0] cellRxPortSelect,
	input wire logic [acr_pkg::ACR_WORD_W-1:0] cellRxWord,
	input wire logic cellRxFirstWord,
	input wire logic cellRxParity
);
	import acr_pkg::*;
	logic [ACR_WORD_W-1:0] seenWord;
	logic seenFirst;
	logic seenParity;

	// ----------------------------------------------------------------
	// idle pins
	// ----------------------------------------------------------------
	initial begin
		cellRxClock = 1'b0;
		cellRxReadEnableN = 1'b1;
		cellRxPortSelect = 2'h0;
	end

	// one receive clock period of eleven system clocks, standing still between calls;
	// far below the ceiling because the port oversamples this clock
	task automatic rx_cycle(input logic enN, input logic [ACR_SEL_W-1:0] sel);
		@(negedge clk);
		cellRxReadEnableN = enN;
		cellRxPortSelect = sel;
		repeat (4) @(negedge clk);
		cellRxClock = 1'b1;
		repeat (6) @(negedge clk);
		// capture just before the falling edge, where the answer has settled
		seenWord = cellRxWord;
		seenFirst = cellRxFirstWord;
		seenParity = cellRxParity;
		cellRxClock = 1'b0;
		// released select shows the inverse so a stale choice is never reused
		cellRxPortSelect = ~sel;
		cellRxReadEnableN = 1'b1;
	endtask
endmodule // acr_cell_layer_model
`default_nettype wire

// file: tb/acr_cell_receive_port_tb_top.sv
// self-checking bench for the cell receive port
`timescale 1ns/1ps
`default_nettype none
module acr_cell_receive_port_tb_top;
	import acr_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk;
	logic rst;
	logic cellInValid;
	logic [ACR_WORD_W-1:0] cellInWord;
	logic cellInLast;
	logic [ACR_SEL_W-1:0] cellInPort;
	logic [ACR_NUM_PORTS-1:0] cellInSpace;
	logic paritySenseSelect;
	logic cellRxClock;
	logic cellRxReadEnableN;
	logic [ACR_SEL_W-1:0] cellRxPortSelect;
	logic [ACR_WORD_W-1:0] cellRxWord;
	logic cellRxFirstWord;
	logic cellRxParity;
	logic [ACR_NUM_PORTS-1:0] cellRxAvailable;
	int failCount;
	int testsRun;

	acr_cell_receive_port u_dut (.clk(clk), .rst(rst), .cellInValid(cellInValid),
		.cellInWord(cellInWord), .cellInLast(cellInLast), .cellInPort(cellInPort),
		.cellInSpace(cellInSpace), .paritySenseSelect(paritySenseSelect),
		.cellRxClock(cellRxClock), .cellRxReadEnableN(cellRxReadEnableN),
		.cellRxPortSelect(cellRxPortSelect), .cellRxWord(cellRxWord),
		.cellRxFirstWord(cellRxFirstWord), .cellRxParity(cellRxParity),
		.cellRxAvailable(cellRxAvailable));

	acr_cell_layer_model u_far (.clk(clk), .cellRxClock(cellRxClock),
		.cellRxReadEnableN(cellRxReadEnableN), .cellRxPortSelect(cellRxPortSelect),
		.cellRxWord(cellRxWord), .cellRxFirstWord(cellRxFirstWord),
		.cellRxParity(cellRxParity));

	// 50 MHz system clock
	always #10 clk = ~clk;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		testsRun++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", name, exp, got);
			failCount++;
		end
	endtask

	// top bit set and every field distinct, so a swapped bit order shows
	function automatic logic [31:0] wd(input logic [1:0] p, input logic [7:0] c,
		input logic [7:0] i);
		return {4'h8, 2'h0, p, c, 8'h5A, i};
	endfunction

	function automatic logic expPar(input logic [31:0] w);
		return paritySenseSelect ? ^w : ~^w;
	endfunction

	task automatic put_cell(input logic [1:0] p, input logic [7:0] c);
		int n;
		for (int i = 0; i < ACR_CELL_WORDS; i++) begin
			@(negedge clk);
			n = 0;
			while (cellInSpace[p] !== 1'b1 && n < 50) begin
				cellInValid = 1'b0;
				@(negedge clk);
				n++;
			end
			check("space wait", 32'h1, {31'h0, cellInSpace[p]});
			cellInValid = 1'b1;
			cellInWord = wd(p, c, 8'(i));
			cellInLast = (i == ACR_CELL_WORDS - 1);
			cellInPort = p;
		end
		@(negedge clk);
		cellInValid = 1'b0;
		cellInLast = 1'b0;
	endtask

	// reads one whole cell; select moves off the port mid-cell and must be ignored
	task automatic read_cell(input logic [1:0] p, input logic [7:0] c, input logic more,
		input int hold);
		logic [31:0] w;
		for (int i = 0; i < ACR_CELL_WORDS; i++) begin
			w = wd(p, c, 8'(i));
			u_far.rx_cycle(1'b0, (i == 0) ? p : p + 2'h1);
			check("word", w, u_far.seenWord);
			check("first", {31'h0, i == 0}, {31'h0, u_far.seenFirst});
			check("parity", {31'h0, expPar(w)}, {31'h0, u_far.seenParity});
			if (i == 1) check("available", {31'h0, more}, {31'h0, cellRxAvailable[p]});
			if (i == hold) begin
				u_far.rx_cycle(1'b1, p);
				check("held word", w, u_far.seenWord);
				check("held first", {31'h0, i == 0}, {31'h0, u_far.seenFirst});
			end
		end
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		check("reset word", ACR_WORD_RST, cellRxWord);
		check("reset first", 32'h0, {31'h0, cellRxFirstWord});
		check("reset parity", {31'h0, ACR_PARITY_RST}, {31'h0, cellRxParity});
		check("reset available", 32'h0, {28'h0, cellRxAvailable});
		check("reset space", 32'hF, {28'h0, cellInSpace});
	endtask

	// one cell per port, each flag on its own index, then drained in order
	task automatic t_port_map();
		logic [3:0] mask;
		mask = 4'h0;
		for (int p = 0; p < ACR_NUM_PORTS; p++) begin
			put_cell(2'(p), 8'(p + 1));
			u_far.rx_cycle(1'b1, 2'h0);
			mask[p] = 1'b1;
			check("port flags", {28'h0, mask}, {28'h0, cellRxAvailable});
		end
		for (int p = 0; p < ACR_NUM_PORTS; p++) begin
			read_cell(2'(p), 8'(p + 1), 1'b0, (p == 3) ? 12 : -1);
		end
		check("drained flags", 32'h0, {28'h0, cellRxAvailable});
	endtask

	// nineteen cells fill most of one 1024-byte buffer; even parity throughout
	task automatic t_deep_even();
		paritySenseSelect = 1'b1;
		for (int c = 0; c < 19; c++) put_cell(2'h0, 8'(c));
		check("space left", 32'h1, {31'h0, cellInSpace[0]});
		u_far.rx_cycle(1'b1, 2'h0);
		check("deep flag", 32'h1, {31'h0, cellRxAvailable[0]});
		for (int c = 0; c < 19; c++) read_cell(2'h0, 8'(c), c < 18, (c == 3) ? 0 : -1);
		paritySenseSelect = 1'b0;
	endtask

	// enable low with no whole cell waiting: word held, marker low
	task automatic t_empty_port();
		u_far.rx_cycle(1'b0, 2'h1);
		check("empty word", wd(2'h0, 8'd18, 8'd12), u_far.seenWord);
		check("empty parity", {31'h0, expPar(wd(2'h0, 8'd18, 8'd12))}, {31'h0, u_far.seenParity});
		check("empty first", 32'h0, {31'h0, u_far.seenFirst});
		check("empty flags", 32'h0, {28'h0, cellRxAvailable});
	endtask

	// fill port 1 word by word while space shows, then offer one refused word;
	// the buffer must take exactly its 1024 bytes and then report no space
	task automatic t_capacity();
		int n;
		n = 0;
		@(negedge clk);
		while (cellInSpace[1] === 1'b1 && n < 300) begin
			cellInValid = 1'b1;
			cellInPort = 2'h1;
			cellInLast = 1'b0;
			cellInWord = wd(2'h1, 8'hFF, 8'(n));
			n++;
			@(negedge clk);
		end
		// one word against the full buffer, which must be dropped
		cellInValid = 1'b1;
		@(negedge clk);
		cellInValid = 1'b0;
		check("buffer words", ACR_FIFO_WORDS, n);
		check("full space", 32'h0, {31'h0, cellInSpace[1]});
	endtask

	// ----------------------------------------------------------------
	// run control
	// ----------------------------------------------------------------
	task automatic conclude();
		if (failCount == 0 && testsRun > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		cellInValid = 1'b0;
		cellInWord = 32'h0000_0000;
		cellInLast = 1'b0;
		cellInPort = 2'h0;
		paritySenseSelect = 1'b0;
		failCount = 0;
		testsRun = 0;
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		t_reset();
		t_port_map();
		t_deep_even();
		t_empty_port();
		t_capacity();
		conclude();
	end

	// the whole run needs about 4000 clocks
	initial begin
		repeat (20000) @(posedge clk);
		failCount++;
		conclude();
	end
endmodule // acr_cell_receive_port_tb_top
`default_nettype wire
